// [epm_counter16.sv]
// Saturating 16-bit event counter read as two bytes, upper byte first.
// Assumes one-cycle event and read pulses in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module epm_counter16 (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       event_in,   // One-cycle event
  input  wire logic       rd_high,    // Read of the upper byte
  input  wire logic       rd_low,     // Read of the lower byte
  output logic [15:0]     count,      // Live count
  output logic [7:0]      high_byte,  // Upper byte read value
  output logic [7:0]      low_byte,   // Lower byte read value
  output logic            armed       // Upper byte read, lower pending
);

  logic [15:0] snap;       // Value taken at upper read
  logic [15:0] next_base;  // Count less what software has taken
  logic        paired;     // Lower read completing a pair

  // Pair completes only after an upper read
  assign paired    = rd_low && armed;
  assign high_byte = count[15:8];
  // lower byte from snapshot when armed
  assign low_byte  = armed ? snap[7:0] : count[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Remove the reported amount, keep later events
  always_comb begin
    next_base = paired ? count - snap : count;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter
  // zero at reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= epm_pkg::CNT16_RESET;
    end else if (event_in && next_base != epm_pkg::CNT16_MAX) begin
      count <= next_base + 16'h0001;
    end else begin
      count <= next_base;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Snapshot and pairing state
  // clear only on ordered pair
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap  <= epm_pkg::CNT16_RESET;
      armed <= 1'b0;
    end else if (rd_high) begin
      snap  <= count;
      armed <= 1'b1;
    end else if (rd_low) begin
      armed <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [epm_counter8.sv]
// Saturating 8-bit event counter that clears on a software read.
// Assumes one-cycle event and clear pulses in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module epm_counter8 (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       event_in,   // One-cycle event
  input  wire logic       clear_in,   // Read of this counter
  output logic [7:0]      count       // Present count
);

  //////////////////////////////////////////////////////////////////////////////
  // Count, clear and saturation
  // zero at reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= epm_pkg::CNT8_RESET;
    end else if (clear_in) begin
      count <= {7'h00, event_in};
    end else if (event_in && count != epm_pkg::CNT8_MAX) begin
      count <= count + 8'h01;
    end
  end

endmodule
`default_nettype wire

// [epm_counter_bank.sv]
// Top of the E1 receive error event counter bank with Wishbone slave.
// Assumes event inputs synchronous to sys_clk from framer, link and checker.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module epm_counter_bank (
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [epm_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // Event sources
  input  wire logic                       frame_loss_state,
  input  wire logic                       lock_strobe,
  input  wire logic [epm_pkg::POS_W-1:0]  locked_position,
  input  wire logic [epm_pkg::POS_W-1:0]  offered_position,
  input  wire logic                       link1_checksum_error,
  input  wire logic                       pattern_bit_error,
  // Interrupt
  output logic                            irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  epm_pkg::epm_events_t ev;           // Events this cycle
  logic                 loss_prev;    // Frame loss level last cycle
  logic [11:0]          idx;          // Word index of access
  logic                 req;          // New request this cycle
  logic                 rd;           // New read
  logic                 wr;           // New write
  logic                 rd_loss;      // Read of frame loss count
  logic                 rd_align;     // Read of alignment count
  logic                 rd_chk;       // Read of checksum count
  logic                 rd_high;      // Read of pattern upper byte
  logic                 rd_low;       // Read of pattern lower byte
  logic [7:0]           loss_cnt;     // Frame loss count
  logic [7:0]           align_cnt;    // Alignment change count
  logic [7:0]           chk_cnt;      // Checksum error count
  logic [15:0]          pat_cnt;      // Pattern error count
  logic [7:0]           pat_high;     // Pattern upper byte
  logic [7:0]           pat_low;      // Pattern lower byte
  logic                 pat_armed;    // Lower read pending
  logic [3:0]           status;       // Sticky event flags
  logic [3:0]           mask;         // Interrupt enables
  logic [3:0]           next_status;  // Flags after this cycle
  logic [31:0]          next_rdata;   // Read mux

  // Word index compare
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: one new request per ack
  assign idx      = wb_adr_i[epm_pkg::ADR_W-1:2];
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd       = req && !wb_we_i;
  assign wr       = req && wb_we_i;
  assign rd_loss  = rd && hit(idx, epm_pkg::IDX_FRAME_LOSS);
  assign rd_align = rd && hit(idx, epm_pkg::IDX_ALIGN_CHANGE);
  assign rd_chk   = rd && hit(idx, epm_pkg::IDX_LINK1_CHKSUM);
  assign rd_high  = rd && hit(idx, epm_pkg::IDX_PATTERN_HIGH);
  assign rd_low   = rd && hit(idx, epm_pkg::IDX_PATTERN_LOW);

  //////////////////////////////////////////////////////////////////////////////
  // Frame loss level history
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loss_prev <= 1'b0;
    end else begin
      loss_prev <= frame_loss_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event forming
  always_comb begin
    ev.frame_loss   = frame_loss_state && !loss_prev;
    ev.align_change = lock_strobe && (locked_position != offered_position);
    ev.link1_chksum = link1_checksum_error;
    ev.pattern_err  = pattern_bit_error;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters
  // frame loss counter
  epm_counter8 u_loss (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .event_in (ev.frame_loss),
    .clear_in (rd_loss),
    .count    (loss_cnt)
  );

  epm_counter8 u_align (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .event_in (ev.align_change),
    .clear_in (rd_align),
    .count    (align_cnt)
  );

  epm_counter8 u_chk (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .event_in (ev.link1_chksum),
    .clear_in (rd_chk),
    .count    (chk_cnt)
  );

  epm_counter16 u_pat (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .event_in  (ev.pattern_err),
    .rd_high   (rd_high),
    .rd_low    (rd_low),
    .count     (pat_cnt),
    .high_byte (pat_high),
    .low_byte  (pat_low),
    .armed     (pat_armed)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags: set wins over write-one clear
  always_comb begin
    next_status = status;
    if (wr && wb_sel_i[0] && hit(idx, epm_pkg::IDX_EVENT_STATUS)) begin
      next_status = status & ~wb_dat_i[3:0];
    end
    next_status = next_status | {ev.pattern_err, ev.link1_chksum,
                                 ev.align_change, ev.frame_loss};
  end

  // Status register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= epm_pkg::FLAGS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= epm_pkg::FLAGS_RESET;
    end else if (wr && wb_sel_i[0] && hit(idx, epm_pkg::IDX_EVENT_MASK)) begin
      mask <= wb_dat_i[3:0];
    end
  end

  // Interrupt level output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      epm_pkg::IDX_FRAME_LOSS:   next_rdata[7:0] = loss_cnt;
      epm_pkg::IDX_ALIGN_CHANGE: next_rdata[7:0] = align_cnt;
      epm_pkg::IDX_LINK1_CHKSUM: next_rdata[7:0] = chk_cnt;
      epm_pkg::IDX_PATTERN_HIGH: next_rdata[7:0] = pat_high;
      epm_pkg::IDX_PATTERN_LOW:  next_rdata[7:0] = pat_low;
      epm_pkg::IDX_EVENT_STATUS: next_rdata[3:0] = status;
      epm_pkg::IDX_EVENT_MASK:   next_rdata[3:0] = mask;
      default:                   next_rdata = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after request, data with it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_hi_quiet;
    rd_high && !ev.pattern_err;
  endsequence

  sequence s_lo_quiet;
    rd_low && !ev.pattern_err;
  endsequence

  loss_edge_a: assert property (ev.frame_loss && !rd_loss && loss_cnt != 8'hFF |=> loss_cnt == $past(loss_cnt) + 8'h01)
    else $error("frame loss count did not advance");
  loss_hold_a: assert property (frame_loss_state && loss_prev && !rd_loss |=> $stable(loss_cnt))
    else $error("frame loss count moved while loss persisted");
  loss_clear_a: assert property (rd_loss && !ev.frame_loss |=> loss_cnt == 8'h00 ##1 wb_ack_o == 1'b0)
    else $error("frame loss count not cleared by read");
  align_same_a: assert property (lock_strobe && locked_position == offered_position && !rd_align |=> $stable(align_cnt))
    else $error("alignment count moved without a change");
  align_count_a: assert property (ev.align_change && !rd_align && align_cnt != 8'hFF |=> align_cnt == $past(align_cnt) + 8'h01)
    else $error("alignment count did not advance");
  chk_sat_a: assert property (chk_cnt == 8'hFF && !rd_chk |=> chk_cnt == 8'hFF)
    else $error("checksum count wrapped");
  chk_keep_a: assert property (rd_chk && ev.link1_chksum |=> chk_cnt == 8'h01)
    else $error("event lost on clearing read");
  pair_clear_a: assert property (s_hi_quiet ##1 (!ev.pattern_err && !rd_high) [*2] ##1 s_lo_quiet |=> pat_cnt == 16'h0000)
    else $error("pattern count not cleared by ordered pair");
  low_alone_a: assert property (rd_low && !pat_armed && !ev.pattern_err |=> $stable(pat_cnt))
    else $error("lower read alone changed pattern count");
  flag_set_a: assert property (ev.align_change |=> status[epm_pkg::BIT_ALIGN_CHANGE] ##1 1'b1)
    else $error("alignment event flag lost");
  bus_ack_a: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");

endmodule
`default_nettype wire

// [epm_counter_bank_test.sv]
// Self-checking bench for the E1 receive error event counter bank.
// Assumes the bank answers each Wishbone request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module epm_counter_bank_test;
  logic        sys_clk;          // 10 MHz clock
  logic        reset_n;          // Active low reset
  logic        wb_cyc;           // Bus cycle
  logic        wb_stb;           // Bus strobe
  logic        wb_we;            // Write when high
  logic [13:0] wb_adr;           // Byte address
  logic [3:0]  wb_sel;           // Byte enables
  logic [31:0] wb_wdat;          // Write data
  logic [31:0] wb_rdat;          // Read data
  logic        wb_ack;           // Bus answer
  logic [3:0]  evs;              // Pattern, checksum, lock, frame loss
  logic [7:0]  lock_pos;         // Newly locked position
  logic [7:0]  offer_pos;        // Offered position
  logic        irq;              // Interrupt level
  logic [31:0] rd;               // Last read value
  int          error_cnt;        // Mismatches
  int          total_checks;     // Comparisons

  ////////////////////////////////////////////////////////////////////////////
  // Row of an ordinary case: event kind, count, register, expected value
  typedef struct {
    int          kind;
    int          num;
    logic [11:0] idx;
    logic [31:0] exp;
  } epm_row_t;
  epm_row_t rows [3];

  // Device under test
  epm_counter_bank epm_counter_bank_i (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .wb_cyc_i             (wb_cyc),
    .wb_stb_i             (wb_stb),
    .wb_we_i              (wb_we),
    .wb_adr_i             (wb_adr),
    .wb_sel_i             (wb_sel),
    .wb_dat_i             (wb_wdat),
    .wb_dat_o             (wb_rdat),
    .wb_ack_o             (wb_ack),
    .frame_loss_state     (evs[0]),
    .lock_strobe          (evs[1]),
    .locked_position      (lock_pos),
    .offered_position     (offer_pos),
    .link1_checksum_error (evs[2]),
    .pattern_bit_error    (evs[3]),
    .irq                  (irq)
  );

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare a register value
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compare the interrupt level
  task automatic chk_irq(input logic exp);
    total_checks++;
    if (irq !== exp) begin
      error_cnt++;
      $display("BAD irq expected %b seen %b", exp, irq);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [11:0] idx, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= 4'hF;
    wb_wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (wb_ack === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      $display("BAD ack expected 1 seen timeout");
      test_done();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // Read a register and compare it
  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    wb_xfer(1'b0, idx, 32'h0000_0000);
    chk_reg(name, exp, rd);
  endtask

  // Separated one-cycle events of one kind
  task automatic ev(input int kind, input int num);
    repeat (num) begin
      @(posedge sys_clk);
      evs <= 4'h1 << kind;
      @(posedge sys_clk);
      evs <= 4'h0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [11:0] all_idx [7];
    error_cnt    = 0;
    total_checks = 0;
    reset_n      = 1'b0;
    wb_cyc       = 1'b0;
    wb_stb       = 1'b0;
    wb_we        = 1'b0;
    wb_adr       = 14'h0000;
    wb_sel       = 4'h0;
    wb_wdat      = 32'h0000_0000;
    evs          = 4'h0;
    lock_pos     = 8'h34;
    offer_pos    = 8'h12;
    rows[0] = '{0, 3, epm_pkg::IDX_FRAME_LOSS,   32'h0000_0003};
    rows[1] = '{1, 2, epm_pkg::IDX_ALIGN_CHANGE, 32'h0000_0002};
    rows[2] = '{2, 5, epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_0005};
    all_idx = '{epm_pkg::IDX_FRAME_LOSS, epm_pkg::IDX_ALIGN_CHANGE, epm_pkg::IDX_LINK1_CHKSUM,
                epm_pkg::IDX_PATTERN_HIGH, epm_pkg::IDX_PATTERN_LOW, epm_pkg::IDX_EVENT_STATUS,
                epm_pkg::IDX_EVENT_MASK};
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (all_idx[i]) rd_chk("reset value", all_idx[i], 32'h0000_0000);
    // Ordinary cases: count, read, read again after the clear
    foreach (rows[i]) begin
      ev(rows[i].kind, rows[i].num);
      rd_chk("count", rows[i].idx, rows[i].exp);
      rd_chk("cleared", rows[i].idx, 32'h0000_0000);
    end
    // Interrupt raised by sticky flags once unmasked, then cleared
    chk_irq(1'b0);
    wb_xfer(1'b1, epm_pkg::IDX_EVENT_MASK, 32'h0000_000F);
    repeat (2) @(posedge sys_clk);
    chk_irq(1'b1);
    rd_chk("status", epm_pkg::IDX_EVENT_STATUS, 32'h0000_0007);
    wb_xfer(1'b1, epm_pkg::IDX_EVENT_STATUS, 32'h0000_0007);
    repeat (2) @(posedge sys_clk);
    chk_irq(1'b0);
    rd_chk("unmapped", 12'h900, 32'h0000_0000);
    // Writes to a counter are ignored
    wb_xfer(1'b1, epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_00FF);
    rd_chk("counter write", epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_0000);
    // Equal positions declare no alignment change
    offer_pos <= 8'h34;
    ev(1, 3);
    rd_chk("same position", epm_pkg::IDX_ALIGN_CHANGE, 32'h0000_0000);
    // Persisting frame loss counts once
    @(posedge sys_clk);
    evs <= 4'h1;
    repeat (10) @(posedge sys_clk);
    evs <= 4'h0;
    rd_chk("held loss", epm_pkg::IDX_FRAME_LOSS, 32'h0000_0001);
    // Saturation of an 8-bit counter
    ev(2, 300);
    rd_chk("saturated", epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_00FF);
    // Event in the same cycle as the clearing read is kept
    fork
      wb_xfer(1'b0, epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_0000);
      begin
        @(posedge sys_clk);
        evs <= 4'h4;
        @(posedge sys_clk);
        evs <= 4'h0;
      end
    join
    chk_reg("clear with event", 32'h0000_0000, rd);
    rd_chk("event kept", epm_pkg::IDX_LINK1_CHKSUM, 32'h0000_0001);
    // Sixteen-bit pattern count read in order, then cleared
    ev(3, 259);
    rd_chk("pattern high", epm_pkg::IDX_PATTERN_HIGH, 32'h0000_0001);
    rd_chk("pattern low", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0003);
    rd_chk("high cleared", epm_pkg::IDX_PATTERN_HIGH, 32'h0000_0000);
    rd_chk("low cleared", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0000);
    // Lower byte alone clears nothing
    ev(3, 2);
    rd_chk("low only", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0002);
    rd_chk("low kept", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0002);
    rd_chk("high pair", epm_pkg::IDX_PATTERN_HIGH, 32'h0000_0000);
    rd_chk("low pair", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0002);
    rd_chk("high again", epm_pkg::IDX_PATTERN_HIGH, 32'h0000_0000);
    rd_chk("low again", epm_pkg::IDX_PATTERN_LOW, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire

// [epm_pkg.sv]
// Constants and types for the E1 receive error event counter bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Functional notes
// - Count each new frame loss declaration once
// - Frame loss count clears when software reads
// - Alignment change count, clear on read
// - Alignment change only when positions differ
// - Link 1 checksum errors counted, clear on read
// - Pattern errors: 16 bits, upper byte readable
// - Ordered upper then lower read subtracts the reported count
// - All counters reset to zero
// - Lower pattern byte readable, clears only after an upper read
package epm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_FRAME_LOSS    = 12'h909;  // Frame loss count
  localparam logic [11:0] IDX_ALIGN_CHANGE  = 12'h90B;  // Alignment change count
  localparam logic [11:0] IDX_LINK1_CHKSUM  = 12'h90C;  // Link 1 checksum errors
  localparam logic [11:0] IDX_PATTERN_HIGH  = 12'h90D;  // Pattern errors, upper byte
  localparam logic [11:0] IDX_PATTERN_LOW   = 12'h90E;  // Pattern errors, lower byte
  localparam logic [11:0] IDX_EVENT_STATUS  = 12'h910;  // Sticky event flags
  localparam logic [11:0] IDX_EVENT_MASK    = 12'h911;  // Interrupt enables

  // Bus geometry and frame position width
  localparam int          ADR_W             = 14;       // Byte address width
  localparam int          POS_W             = 8;        // Frame position width

  // Reset values and saturation limits
  localparam logic [7:0]  CNT8_RESET        = 8'h00;
  localparam logic [15:0] CNT16_RESET       = 16'h0000;
  localparam logic [3:0]  FLAGS_RESET       = 4'h0;
  localparam logic [7:0]  CNT8_MAX          = 8'hFF;
  localparam logic [15:0] CNT16_MAX         = 16'hFFFF;

  // Event flag bit positions in status and mask
  localparam int          BIT_FRAME_LOSS    = 0;
  localparam int          BIT_ALIGN_CHANGE  = 1;
  localparam int          BIT_LINK1_CHKSUM  = 2;
  localparam int          BIT_PATTERN_ERR   = 3;

  // One-cycle events feeding counters and flags
  typedef struct packed {
    logic pattern_err;    // Bit 3
    logic link1_chksum;   // Bit 2
    logic align_change;   // Bit 1
    logic frame_loss;     // Bit 0
  } epm_events_t;

endpackage
